// ### mac_event_pkg.sv
package mac_event_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_EVENT_STATUS = 8'h00;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] OFS_PHY_STATUS = 8'h08;
   localparam logic [7:0] OFS_MAC_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_PAUSE_LIMIT = 8'h10;

   // ==========================================================
   // field positions
   localparam int BIT_ILLEGAL_CARRIER = 0;
   localparam int BIT_WAKE_PACKET = 1;
   localparam int BIT_LINK_CHANGE = 2;
   localparam int BIT_RESERVED = 3;
   localparam int BIT_PAUSE_OVER = 4;
   localparam int BIT_LINK_MONITOR = 0;
   localparam int BIT_FLOW_CTRL_EN = 0;
   localparam int EVENT_W = 5;

   // ==========================================================
   // masks and reset values
   localparam logic [4:0] EVENT_MASK = 5'h17;
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic [4:0] IRQ_EN_RST = 5'h00;
   localparam logic FLOW_CTRL_RST = 1'b0;
   localparam int PAUSE_LIMIT_W = 16;
   localparam logic [15:0] PAUSE_LIMIT_RST = 16'h0000;

   // ==========================================================
   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_WRITE = 3'b010,
      PH_READ = 3'b100
   } bus_phase_t;

endpackage

// ### event_edge_detect.sv
// ==========================================================
// edge detector for status levels from the phy
module event_edge_detect
   import mac_event_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   typedef struct packed {
      logic [WIDTH-1:0] prev;
      logic armed;
   } edge_state_t;

   edge_state_t st;
   edge_state_t next_st;

   // no edges reported until one sample has been taken after reset
   assign rise = st.armed ? (level & ~st.prev) : '0;
   assign fall = st.armed ? (~level & st.prev) : '0;

   // sample the level every cycle
   always_comb begin
      next_st = st;
      next_st.prev = level;
      next_st.armed = 1'b1;
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // event_edge_detect

// ### mac_event_status.sv
// Contract
// - status reads zero in bits 31:5 and 3
// - writing one clears that event flag
// - writing zero leaves a flag unchanged
// - each flag interrupts only when enabled
// - enabled flags combine into one summary bit
// - pause retries beyond limit set bit 4
// - any link level transition sets bit 2
// - present link level readable separately
// - wake packet detection sets bit 1
// - illegal carrier from phy sets bit 0
// - enables share flag positions, reset zero
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
module mac_event_status
   import mac_event_pkg::*;
#(
   parameter int LIMIT_W = PAUSE_LIMIT_W
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   // ==========================================================
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // ==========================================================
   // event sources
   input wire logic phy_link_input,
   input wire logic phy_illegal_carrier,
   input wire logic wake_packet_detect,
   input wire logic pause_retry_pulse,
   input wire logic pause_retry_done,
   // ==========================================================
   // interrupt outputs
   output logic irq,
   output logic mac_event_summary_bit
);

   typedef struct packed {
      bus_phase_t phase;
      logic [31:0] addr;
      logic [4:0] status;
      logic [4:0] irq_en;
      logic flow_ctrl_en;
      logic [LIMIT_W-1:0] retry_limit;
      logic [LIMIT_W-1:0] retry_count;
      logic link_level;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic irq;
      logic summary;
   } state_t;

   state_t st;
   state_t next_st;

   logic [1:0] rise;
   logic [1:0] fall;
   logic link_evt;
   logic carrier_evt;
   logic over_evt;
   logic take;
   logic [4:0] set_vec;
   logic [4:0] clr_vec;
   logic pending;

   // ==========================================================
   // address match: upper bits zero and low byte equal offset
   function automatic logic is_reg(input logic [31:0] a,
                                   input logic [7:0] ofs);
      is_reg = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
   endfunction

   // ==========================================================
   // phy level edges
   event_edge_detect #(
      .WIDTH(2)
   ) u_edges (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .level({phy_illegal_carrier, phy_link_input}),
      .rise(rise),
      .fall(fall)
   );

   // both directions of the link level count as a change
   assign link_evt = rise[0] | fall[0];
   // carrier is captured on its rising edge so a clear can stick
   assign carrier_evt = rise[1];
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
   // combined enabled flags as currently held
   assign pending = |(st.status & st.irq_en);

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      over_evt = 1'b0;
      clr_vec = 5'h00;
      next_st.hreadyout = 1'b1;
      next_st.hresp = HRESP_OKAY;

      // retry counting only while flow control is on
      if (pause_retry_done) begin
         next_st.retry_count = '0;
      end else if (st.flow_ctrl_en && pause_retry_pulse) begin
         if (st.retry_count >= st.retry_limit) begin
            over_evt = 1'b1;
         end
         if (st.retry_count != {LIMIT_W{1'b1}}) begin
            next_st.retry_count = st.retry_count + 1'b1;
         end
      end

      // event set vector at the flag positions
      set_vec = 5'h00;
      set_vec[BIT_PAUSE_OVER] = over_evt;
      set_vec[BIT_LINK_CHANGE] = link_evt;
      set_vec[BIT_WAKE_PACKET] = wake_packet_detect;
      set_vec[BIT_ILLEGAL_CARRIER] = carrier_evt;

      // data phase of a write
      if (st.phase == PH_WRITE) begin
         if (is_reg(st.addr, OFS_EVENT_STATUS)) begin
            // ones clear, zeros keep
            clr_vec = hwdata[4:0] & EVENT_MASK;
         end
         if (is_reg(st.addr, OFS_IRQ_ENABLE)) begin
            next_st.irq_en = hwdata[4:0] & EVENT_MASK;
         end
         if (is_reg(st.addr, OFS_MAC_CONTROL)) begin
            next_st.flow_ctrl_en = hwdata[BIT_FLOW_CTRL_EN];
         end
         if (is_reg(st.addr, OFS_PAUSE_LIMIT)) begin
            next_st.retry_limit = hwdata[LIMIT_W-1:0];
         end
      end

      // sticky flags: a set in the clearing cycle wins
      next_st.status = ((st.status & ~clr_vec) | set_vec)
                       & EVENT_MASK;

      // present link level kept apart from the change flag
      next_st.link_level = phy_link_input;

      // interrupt and summary follow the updated flags
      next_st.irq = |(next_st.status & next_st.irq_en);
      next_st.summary = |(next_st.status & next_st.irq_en);

      // address phase
      next_st.hrdata = 32'h00000000;
      if (take) begin
         next_st.addr = haddr;
         next_st.phase = hwrite ? PH_WRITE : PH_READ;
         // read data reflects any write finishing in this cycle
         if (!hwrite) begin
            if (is_reg(haddr, OFS_EVENT_STATUS)) begin
               next_st.hrdata[4:0] = next_st.status;
            end else if (is_reg(haddr, OFS_IRQ_ENABLE)) begin
               next_st.hrdata[4:0] = next_st.irq_en;
            end else if (is_reg(haddr, OFS_PHY_STATUS)) begin
               next_st.hrdata[BIT_LINK_MONITOR] =
                  next_st.link_level;
            end else if (is_reg(haddr, OFS_MAC_CONTROL)) begin
               next_st.hrdata[BIT_FLOW_CTRL_EN] = next_st.flow_ctrl_en;
            end else if (is_reg(haddr, OFS_PAUSE_LIMIT)) begin
               next_st.hrdata[LIMIT_W-1:0] = next_st.retry_limit;
            end
         end
      end else if (hready) begin
         next_st.phase = PH_IDLE;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st.phase <= PH_IDLE;
         st.addr <= 32'h00000000;
         st.status <= STATUS_RST;
         st.irq_en <= IRQ_EN_RST;
         st.flow_ctrl_en <= FLOW_CTRL_RST;
         st.retry_limit <= LIMIT_W'(PAUSE_LIMIT_RST);
         st.retry_count <= '0;
         st.link_level <= 1'b0;
         st.hrdata <= 32'h00000000;
         st.hreadyout <= 1'b1;
         st.hresp <= HRESP_OKAY;
         st.irq <= 1'b0;
         st.summary <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata = st.hrdata;
   assign hreadyout = st.hreadyout;
   assign hresp = st.hresp;
   assign irq = st.irq;
   assign mac_event_summary_bit = st.summary;

   // ==========================================================
   // assertions
   property p_reserved_zero;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.phase == PH_READ && is_reg(st.addr, OFS_EVENT_STATUS))
         |-> (hrdata[31:5] == 27'h0000000 && hrdata[3] == 1'b0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved status bits read nonzero");

   property p_clear_one;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.phase == PH_WRITE && is_reg(st.addr, OFS_EVENT_STATUS)
          && hwdata[BIT_WAKE_PACKET] && !wake_packet_detect)
         |=> !st.status[BIT_WAKE_PACKET];
   endproperty
   a_clear_one: assert property (p_clear_one)
      else $error("write of one did not clear flag");

   property p_zero_keeps;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.phase == PH_WRITE && is_reg(st.addr, OFS_EVENT_STATUS)
          && !hwdata[BIT_LINK_CHANGE] && st.status[BIT_LINK_CHANGE])
         |=> st.status[BIT_LINK_CHANGE];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps)
      else $error("write of zero disturbed flag");

   property p_masked_quiet;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.irq_en == 5'h00) |-> !irq;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet)
      else $error("interrupt raised with all enables off");

   property p_summary_tracks;
      @(posedge sys_clk) disable iff (sys_rst)
         mac_event_summary_bit == pending;
   endproperty
   a_summary_tracks: assert property (p_summary_tracks)
      else $error("summary bit differs from enabled flags");

   property p_retry_over;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.flow_ctrl_en && pause_retry_pulse && !pause_retry_done
          && st.retry_count >= st.retry_limit)
         |=> st.status[BIT_PAUSE_OVER] && irq == pending;
   endproperty
   a_retry_over: assert property (p_retry_over)
      else $error("retry overflow not flagged");

   property p_link_change;
      @(posedge sys_clk) disable iff (sys_rst)
         ($changed(phy_link_input) && u_edges.st.armed)
         |=> st.status[BIT_LINK_CHANGE];
   endproperty
   a_link_change: assert property (p_link_change)
      else $error("link transition not flagged");

   property p_link_level;
      @(posedge sys_clk) disable iff (sys_rst)
         ##1 st.link_level == $past(phy_link_input);
   endproperty
   a_link_level: assert property (p_link_level)
      else $error("link monitor does not follow link input");

   property p_wake;
      @(posedge sys_clk) disable iff (sys_rst)
         wake_packet_detect |=> st.status[BIT_WAKE_PACKET];
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake packet not flagged");

   property p_carrier;
      @(posedge sys_clk) disable iff (sys_rst)
         $rose(phy_illegal_carrier) && u_edges.st.armed
         |=> st.status[BIT_ILLEGAL_CARRIER];
   endproperty
   a_carrier: assert property (p_carrier)
      else $error("illegal carrier not flagged");

   property p_enable_pos;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.phase == PH_WRITE && is_reg(st.addr, OFS_IRQ_ENABLE))
         |=> st.irq_en == ($past(hwdata[4:0]) & EVENT_MASK);
   endproperty
   a_enable_pos: assert property (p_enable_pos)
      else $error("enable register not stored at flag positions");

   property p_set_wins;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.phase == PH_WRITE && is_reg(st.addr, OFS_EVENT_STATUS)
          && hwdata[BIT_WAKE_PACKET] && wake_packet_detect)
         |=> st.status[BIT_WAKE_PACKET] [*1] ##0 !$fell(irq) [*1];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost under same-cycle clear");

   property p_irq_or;
      @(posedge sys_clk) disable iff (sys_rst)
         irq == pending;
   endproperty
   a_irq_or: assert property (p_irq_or)
      else $error("interrupt is not or of enabled flags");

   property p_sticky;
      @(posedge sys_clk) disable iff (sys_rst)
         (st.status[BIT_PAUSE_OVER] && st.phase != PH_WRITE)
         |=> st.status[BIT_PAUSE_OVER];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without a clearing write");

endmodule // mac_event_status

// ### phy_link_model.sv
// ==========================================================
// phy side: link level and illegal carrier indication
module phy_link_model #(
   parameter int HOLD = 4
) (
   input wire logic sys_clk,
   input wire logic link_flip,
   input wire logic carrier_req,
   output logic phy_link_input,
   output logic phy_illegal_carrier
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold_cnt;

   initial begin
      phy_link_input = 1'b0;
      phy_illegal_carrier = 1'b0;
      hold_cnt = 0;
   end

   // link level toggles on request; carrier held for several cycles
   always @(posedge sys_clk) begin
      if (link_flip)
         phy_link_input <= !phy_link_input;
      if (carrier_req)
         hold_cnt <= HOLD;
      else if (hold_cnt > 0)
         hold_cnt <= hold_cnt - 1;
      phy_illegal_carrier <= carrier_req || hold_cnt > 1;
   end
endmodule // phy_link_model

// ### mac_event_status_flags_test.sv
// ==========================================================
// bench for the event status flags
module mac_event_status_flags_test;
   import mac_event_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, sys_rst, hsel, hwrite, link_flip, carrier_req;
   logic [31:0] haddr, hwdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic wake_packet_detect, pause_retry_pulse, pause_retry_done;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, irq, mac_event_summary_bit;
   wire logic phy_link_input, phy_illegal_carrier;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   // selectors of the event input that pulse drives
   localparam int SRC_LINK = 0;
   localparam int SRC_CARRIER = 1;
   localparam int SRC_WAKE = 2;
   localparam int SRC_RETRY = 3;
   localparam int SRC_DONE = 4;

   mac_event_status i_mac_event_status (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .phy_link_input(phy_link_input),
      .phy_illegal_carrier(phy_illegal_carrier),
      .wake_packet_detect(wake_packet_detect),
      .pause_retry_pulse(pause_retry_pulse),
      .pause_retry_done(pause_retry_done), .irq(irq),
      .mac_event_summary_bit(mac_event_summary_bit));

   phy_link_model i_phy_link_model (.sys_clk(sys_clk),
      .link_flip(link_flip), .carrier_req(carrier_req),
      .phy_link_input(phy_link_input),
      .phy_illegal_carrier(phy_illegal_carrier));

   // ==========================================================
   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = !sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // address phase then data phase, each held until hready
   task automatic bus(input logic [7:0] ofs, input logic wr,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, ofs};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      check({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      bus(ofs, 1'b1, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
      bus(ofs, 1'b0, 32'h0, r);
      check(r, exp);
   endtask

   // set one event input of the module scope to a level
   task automatic drive(input int sel, input logic v);
      case (sel)
         SRC_LINK: link_flip <= v;
         SRC_CARRIER: carrier_req <= v;
         SRC_WAKE: wake_packet_detect <= v;
         SRC_RETRY: pause_retry_pulse <= v;
         default: pause_retry_done <= v;
      endcase
   endtask

   // one-cycle pulses on the chosen input, then two quiet cycles
   task automatic pulse(input int sel, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         drive(sel, 1'b1);
         @(posedge sys_clk);
         drive(sel, 1'b0);
      end
      repeat (2) @(posedge sys_clk);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_chk(OFS_EVENT_STATUS, 32'h0);
      rd_chk(OFS_IRQ_ENABLE, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask

   task automatic t_link();
      pulse(SRC_LINK, 1);
      rd_chk(OFS_EVENT_STATUS, 32'h4);
      rd_chk(OFS_PHY_STATUS, 32'h1);
      wr(OFS_EVENT_STATUS, 32'h0);
      rd_chk(OFS_EVENT_STATUS, 32'h4);
      wr(OFS_EVENT_STATUS, 32'h4);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
      pulse(SRC_LINK, 1);
      rd_chk(OFS_EVENT_STATUS, 32'h4);
      rd_chk(OFS_PHY_STATUS, 32'h0);
      wr(OFS_EVENT_STATUS, 32'h4);
   endtask

   task automatic t_flags();
      pulse(SRC_CARRIER, 1);
      pulse(SRC_WAKE, 1);
      rd_chk(OFS_EVENT_STATUS, 32'h3);
      wr(OFS_EVENT_STATUS, 32'hFFFFFFFF);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
      wr(OFS_IRQ_ENABLE, 32'hFFFFFFFF);
      rd_chk(OFS_IRQ_ENABLE, 32'h17);
      wr(OFS_IRQ_ENABLE, 32'h0);
   endtask

   task automatic t_irq();
      wr(OFS_IRQ_ENABLE, 32'h2);
      pulse(SRC_CARRIER, 1);
      check({31'h0, irq}, 32'h0);
      pulse(SRC_WAKE, 1);
      check({31'h0, irq}, 32'h1);
      check({31'h0, mac_event_summary_bit}, 32'h1);
      wr(OFS_EVENT_STATUS, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(OFS_EVENT_STATUS, 32'h2);
      @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      check({31'h0, mac_event_summary_bit}, 32'h0);
      wr(OFS_IRQ_ENABLE, 32'h0);
   endtask

   // event held across the clearing write keeps the flag
   task automatic t_sticky();
      @(posedge sys_clk);
      wake_packet_detect <= 1'b1;
      wr(OFS_EVENT_STATUS, 32'h2);
      wake_packet_detect <= 1'b0;
      rd_chk(OFS_EVENT_STATUS, 32'h2);
      wr(OFS_EVENT_STATUS, 32'h2);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
   endtask

   task automatic t_pause();
      wr(OFS_PAUSE_LIMIT, 32'h2);
      pulse(SRC_RETRY, 3);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
      pulse(SRC_DONE, 1);
      wr(OFS_MAC_CONTROL, 32'h1);
      wr(OFS_IRQ_ENABLE, 32'h10);
      pulse(SRC_RETRY, 2);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
      pulse(SRC_RETRY, 1);
      rd_chk(OFS_EVENT_STATUS, 32'h10);
      check({31'h0, irq}, 32'h1);
      wr(OFS_EVENT_STATUS, 32'h10);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
   endtask

   task automatic t_unmapped();
      wr(8'h14, 32'hFFFFFFFF);
      rd_chk(8'h14, 32'h0);
      rd_chk(OFS_EVENT_STATUS, 32'h0);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      link_flip = 1'b0;
      carrier_req = 1'b0;
      wake_packet_detect = 1'b0;
      pause_retry_pulse = 1'b0;
      pause_retry_done = 1'b0;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_link();
      t_flags();
      t_irq();
      t_sticky();
      t_pause();
      t_unmapped();
      report_and_stop();
   end
endmodule // mac_event_status_flags_test
